// ===== rtl/shpp_port.sv
// strobed and handshake parallel port with ahb-lite register slave
// Behaviour
// - simple mode: port b write pulses strobe
// - polarity bit sets strobe active level
// - input hs edge latches, flags, drops ready
// - input hs latch read reasserts ready
// - input hs port read gives pins
// - input hs writes share output latch
// - output hs edge drops ready, sets flag
// - output hs latch write drives, asserts ready
// - output hs active strobe forces outputs
// - output hs port c reads return output latch
// - strobes only in single-chip mode
// - control register writable except flag bit
// - simple/input: control read then latch read
// - output: control read then latch write
// - irq when flag, enable, mask clear
// - wired-or makes port c outputs open-drain
// - handshake select: simple or full
// - pulse select: level or pulse strobe
// - direction bit: input or output handshake
// - pulse two cycles, level until edge
// - edge select bit, opposite level forces
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "shpp_params.svh"
module shpp_port
  import shpp_pkg::*;
(
  input  wire logic        core_clk_in,      // 10 MHz bus clock
  input  wire logic        rst_in,           // synchronous reset, high
  input  wire logic        hsel_in,          // ahb select
  input  wire logic [31:0] haddr_in,         // ahb address
  input  wire logic [1:0]  htrans_in,        // ahb transfer type
  input  wire logic        hwrite_in,        // ahb write
  input  wire logic [2:0]  hsize_in,         // ahb size
  input  wire logic        hready_in,        // ahb bus ready
  input  wire logic [31:0] hwdata_in,        // ahb write data
  output logic             hreadyout_out,    // ahb ready out
  output logic [31:0]      hrdata_out,       // ahb read data
  output logic             hresp_out,        // ahb response, always okay
  input  wire logic        single_chip_in,   // device in single-chip mode
  input  wire logic        irq_mask_in,      // processor global mask, high masks
  input  wire logic        edge_strobe_input_in,  // strobe from peripheral
  input  wire logic [7:0]  port_c_in,        // port c pin levels
  output logic [7:0]       port_c_out,       // port c drive value
  output logic [7:0]       port_c_oe_out,    // port c output enables
  output logic [7:0]       port_b_out,       // output-only port
  output logic             ready_strobe_output_out, // strobe / ready pin
  output logic             irq_out           // interrupt request
);
  shpp_state_t s_r;   // registered state
  shpp_state_t s_nxt; // next state

  // decode the working mode from control bits
  function automatic shpp_mode_t mode_of(input logic [7:0] c);
    if (!c[`SHPP_BIT_HANDSHAKE_SELECT]) begin
      mode_of = SHPP_MODE_SIMPLE;
    end else if (c[`SHPP_BIT_DIR]) begin
      mode_of = SHPP_MODE_OUT_HS;
    end else begin
      mode_of = SHPP_MODE_IN_HS;
    end
  endfunction

  shpp_mode_t mode;       // current mode
  logic       rise;       // filtered strobe rose
  logic       fall;       // filtered strobe fell
  logic       sel_edge;   // selected edge seen
  logic       new_sig;    // agreed strobe level
  logic       addr_ok;    // address phase accepted
  logic       rd_ctrl;    // control read completes
  logic       rd_latch;   // latch read completes
  logic       wr_latch;   // latch write completes
  logic       wr_pinc;    // port c write completes
  logic       wr_portb;   // port b write completes
  logic       ready_strobe_output_act;   // strobe input at active level
  logic [7:0] wdata;      // low byte of write data
  logic [7:0] pinval;     // value read from port c
  logic       fset;       // flag set event
  logic       fclr;       // flag clear event

  // combinational next state
  always_comb begin
    s_nxt    = s_r;
    mode     = mode_of(s_r.ctrl);
    wdata    = hwdata_in[7:0];
    // change counts once second and third stages agree
    new_sig  = (s_r.sync[1] == s_r.sync[2]) ? s_r.sync[2] : s_r.ready_strobe_output_sig;
    rise     = new_sig & ~s_r.ready_strobe_output_sig;
    fall     = ~new_sig & s_r.ready_strobe_output_sig;
    sel_edge = single_chip_in & (s_r.ctrl[`SHPP_BIT_EDGE] ? rise : fall);
    // active level is the one opposite the post-edge level
    ready_strobe_output_act = s_r.ready_strobe_output_sig ^ s_r.ctrl[`SHPP_BIT_EDGE];
    s_nxt.sync     = {s_r.sync[1:0], edge_strobe_input_in};
    s_nxt.ready_strobe_output_sig = new_sig;

    // ahb: zero wait states, data phase follows accepted address phase
    addr_ok  = hsel_in & hready_in & htrans_in[1];
    rd_ctrl  = s_r.dph & ~s_r.dwr & (s_r.daddr == `SHPP_ADDR_CTRL);
    rd_latch = s_r.dph & ~s_r.dwr & (s_r.daddr == `SHPP_ADDR_LATCH);
    wr_latch = s_r.dph & s_r.dwr & (s_r.daddr == `SHPP_ADDR_LATCH);
    wr_pinc  = s_r.dph & s_r.dwr & (s_r.daddr == `SHPP_ADDR_PINC);
    wr_portb = s_r.dph & s_r.dwr & (s_r.daddr == `SHPP_ADDR_PORTB);
    s_nxt.hready = 1'b1;
    s_nxt.dph    = addr_ok;
    s_nxt.dwr    = hwrite_in;
    s_nxt.daddr  = {haddr_in[7:2], 2'b00};

    // read mux, prepared in the address phase so data stands in data phase
    pinval = (mode == SHPP_MODE_OUT_HS) ? s_r.outc :
             ((port_c_in & ~s_r.dirc) | (s_r.outc & s_r.dirc));
    s_nxt.hrdata = 32'h0000_0000;
    if (addr_ok && !hwrite_in) begin
      unique case ({haddr_in[7:2], 2'b00})
        `SHPP_ADDR_CTRL:  s_nxt.hrdata = {24'h00_0000, s_r.ctrl};
        `SHPP_ADDR_PINC:  s_nxt.hrdata = {24'h00_0000, pinval};
        `SHPP_ADDR_LATCH: s_nxt.hrdata = {24'h00_0000, s_r.latch};
        `SHPP_ADDR_DIRC:  s_nxt.hrdata = {24'h00_0000, s_r.dirc};
        `SHPP_ADDR_PORTB: s_nxt.hrdata = {24'h00_0000, s_r.portb};
        default:          s_nxt.hrdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end

    // register writes; flag bit is not writable
    if (s_r.dph && s_r.dwr) begin
      unique case (s_r.daddr)
        `SHPP_ADDR_CTRL: s_nxt.ctrl = (s_r.ctrl & ~`SHPP_CTRL_WMASK) |
                                      (wdata & `SHPP_CTRL_WMASK);
        `SHPP_ADDR_DIRC:  s_nxt.dirc  = wdata;
        `SHPP_ADDR_PORTB: s_nxt.portb = wdata;
        default: ;
      endcase
    end
    // both port c addresses feed one output latch; only a latch write in output hs touches the strobe
    if (wr_pinc || wr_latch) begin
      s_nxt.outc = wdata;
    end

    // arm the clear sequence on a control read that shows the flag
    if (rd_ctrl) begin
      s_nxt.armed = s_r.ctrl[`SHPP_BIT_FLAG];
    end
    fclr = s_r.armed & ((mode == SHPP_MODE_OUT_HS) ? wr_latch : rd_latch);
    if (fclr) begin
      s_nxt.armed = 1'b0;
    end
    fset = sel_edge;
    // a set in the same cycle as a clear wins
    if (fset) begin
      s_nxt.ctrl[`SHPP_BIT_FLAG] = 1'b1;
    end else if (fclr) begin
      s_nxt.ctrl[`SHPP_BIT_FLAG] = 1'b0;
    end

    // capture port c on every selected edge outside output handshake
    if (sel_edge && mode != SHPP_MODE_OUT_HS) begin
      s_nxt.latch = port_c_in;
    end

    // ready strobe sequencing
    if (s_r.pcnt != 2'd0) begin
      s_nxt.pcnt = s_r.pcnt - 2'd1;
    end
    unique case (mode)
      SHPP_MODE_SIMPLE: begin
        s_nxt.ready = 1'b0;
        if (wr_portb && single_chip_in) begin
          s_nxt.pcnt = 2'(`SHPP_READY_STROBE_OUTPUT_CYCLES);
        end
      end
      default: begin
        if (sel_edge) begin
          s_nxt.ready = 1'b0;
          s_nxt.pcnt  = 2'd0;
        end else if ((mode == SHPP_MODE_IN_HS && rd_latch) ||
                     (mode == SHPP_MODE_OUT_HS && wr_latch)) begin
          s_nxt.ready = 1'b1;
          s_nxt.pcnt  = 2'(`SHPP_READY_STROBE_OUTPUT_CYCLES);
        end
      end
    endcase
    // pulsed mode drops ready when the count runs out, interlocked holds it
    if (mode != SHPP_MODE_SIMPLE && s_r.ctrl[`SHPP_BIT_PLS] &&
        s_r.pcnt == 2'd1 && !s_nxt.ready) begin
      s_nxt.ready = 1'b0;
    end
    if (mode != SHPP_MODE_SIMPLE && s_r.ctrl[`SHPP_BIT_PLS] && s_r.pcnt == 2'd1) begin
      s_nxt.ready = 1'b0;
    end

    // strobe pin: active while pulse runs (simple/pulsed) or ready level held
    s_nxt.ready_strobe_output_pin = s_r.ctrl[`SHPP_BIT_POL] ^ 1'b1; // inactive level
    if (single_chip_in) begin
      if (mode == SHPP_MODE_SIMPLE || s_r.ctrl[`SHPP_BIT_PLS]) begin
        if (s_nxt.pcnt != 2'd0) begin
          s_nxt.ready_strobe_output_pin = s_r.ctrl[`SHPP_BIT_POL];
        end
      end else if (s_nxt.ready) begin
        s_nxt.ready_strobe_output_pin = s_r.ctrl[`SHPP_BIT_POL];
      end
    end

    // port c drivers; active strobe enables all outputs in output hs, before the open-drain mask
    s_nxt.poe = s_r.dirc;
    if (single_chip_in && mode == SHPP_MODE_OUT_HS && ready_strobe_output_act) begin
      s_nxt.poe = 8'hFF;
    end
    s_nxt.pdo = s_nxt.outc;
    if (s_r.ctrl[`SHPP_BIT_WOR]) begin
      // open drain: drive only the zeros
      s_nxt.poe = s_nxt.poe & ~s_nxt.outc;
      s_nxt.pdo = 8'h00;
    end

    s_nxt.irq = s_nxt.ctrl[`SHPP_BIT_FLAG] & s_nxt.ctrl[`SHPP_BIT_IRQEN] &
                ~irq_mask_in;
  end

  // state register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_r          <= '0;
      s_r.ctrl     <= `SHPP_CTRL_RESET;
      s_r.sync     <= 3'b111;
      s_r.ready_strobe_output_sig <= 1'b1;
      s_r.hready   <= 1'b1;
      s_r.ready_strobe_output_pin <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flip-flops, except hresp tied to okay
  always_comb begin
    hreadyout_out           = s_r.hready;
    hrdata_out              = s_r.hrdata;
    hresp_out               = 1'b0;
    port_c_out              = s_r.pdo;
    port_c_oe_out           = s_r.poe;
    port_b_out              = s_r.portb;
    ready_strobe_output_out = s_r.ready_strobe_output_pin;
    irq_out                 = s_r.irq;
  end

  // flag rises one cycle after a selected edge
  AST_FLAG_SET: assert property (@(posedge core_clk_in) disable iff (rst_in)
    sel_edge |=> s_r.ctrl[`SHPP_BIT_FLAG])
    else $error("flag not set after edge");
  // simple mode port b write gives active strobe two cycles
  AST_PULSE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (wr_portb && single_chip_in && mode == SHPP_MODE_SIMPLE &&
     $stable(s_r.ctrl)) |=> (ready_strobe_output_out == s_r.ctrl[0]) [*2])
    else $error("strobe pulse wrong");
  // edge in handshake deasserts ready
  AST_READY_DROP: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (sel_edge && mode != SHPP_MODE_SIMPLE) |=> !s_r.ready)
    else $error("ready not dropped");
  // latch read in input hs asserts ready
  AST_READY_IN: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (rd_latch && !sel_edge && mode == SHPP_MODE_IN_HS) |=> s_r.ready)
    else $error("ready not reasserted");
  // latch write in output hs asserts ready and drives data
  AST_READY_OUT: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (wr_latch && !sel_edge && mode == SHPP_MODE_OUT_HS) |=>
     (s_r.ready && s_r.outc == $past(wdata)))
    else $error("output hs write wrong");
  // irq follows flag, enable and mask
  AST_IRQ: assert property (@(posedge core_clk_in) disable iff (rst_in)
    irq_out == (s_r.ctrl[7] & s_r.ctrl[6] & ~$past(irq_mask_in)))
    else $error("irq mismatch");
  // output hs with active strobe and no wired-or drives all lines
  AST_FORCE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (single_chip_in && mode == SHPP_MODE_OUT_HS && ready_strobe_output_act &&
     !s_r.ctrl[`SHPP_BIT_WOR]) |=> port_c_oe_out == 8'hFF)
    else $error("port c not forced");
  // flag is untouched by control writes
  AST_FLAG_RO: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (s_r.dph && s_r.dwr && s_r.daddr == `SHPP_ADDR_CTRL && !fset && !fclr) |=>
     $stable(s_r.ctrl[7]))
    else $error("flag written");
  // completed clear sequence clears flag
  AST_CLEAR: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (fclr && !fset) |=> !s_r.ctrl[`SHPP_BIT_FLAG])
    else $error("flag not cleared");
  // no strobe activity outside single-chip mode
  AST_SINGLE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !single_chip_in |-> !sel_edge)
    else $error("edge outside single-chip");
endmodule

// ===== shared/shpp_params.svh
// constants for the strobed handshake parallel port
`ifndef SHPP_PARAMS_SVH
`define SHPP_PARAMS_SVH
`define SHPP_ADDR_CTRL     8'h00
`define SHPP_ADDR_PINC     8'h04
`define SHPP_ADDR_LATCH    8'h08
`define SHPP_ADDR_DIRC     8'h0C
`define SHPP_ADDR_PORTB    8'h10
`define SHPP_ADDR_MISC     8'h14
`define SHPP_BIT_FLAG      7
`define SHPP_BIT_IRQEN     6
`define SHPP_BIT_WOR       5
`define SHPP_BIT_HANDSHAKE_SELECT      4
`define SHPP_BIT_DIR       3
`define SHPP_BIT_PLS       2
`define SHPP_BIT_EDGE      1
`define SHPP_BIT_POL       0
`define SHPP_CTRL_RESET    8'h03
`define SHPP_CTRL_WMASK    8'h7F
`define SHPP_READY_STROBE_OUTPUT_PERIODS  2
`define SHPP_PERIOD_NS     100
`define SHPP_READY_STROBE_OUTPUT_NS       (`SHPP_READY_STROBE_OUTPUT_PERIODS * `SHPP_PERIOD_NS)
`define SHPP_READY_STROBE_OUTPUT_CYCLES   ((`SHPP_READY_STROBE_OUTPUT_NS + `SHPP_PERIOD_NS - 1) / `SHPP_PERIOD_NS)
`endif

// ===== shared/shpp_pkg.sv
// types for the strobed handshake parallel port
package shpp_pkg;
  typedef enum logic [1:0] {
    SHPP_MODE_SIMPLE = 2'b00,
    SHPP_MODE_IN_HS  = 2'b01,
    SHPP_MODE_OUT_HS = 2'b10
  } shpp_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;      // control bits, flag in bit 7
    logic [7:0] outc;      // shared port c output latch
    logic [7:0] dirc;      // port c direction bits
    logic [7:0] latch;     // captured port c value
    logic [7:0] portb;     // output-only port
    logic [2:0] sync;      // strobe input synchroniser
    logic       ready_strobe_output_sig;  // filtered strobe input level
    logic       armed;     // control read seen with flag set
    logic       ready;     // ready strobe logically active
    logic [1:0] pcnt;      // pulse length counter
    logic       hready;    // ahb ready out
    logic [31:0] hrdata;   // ahb read data
    logic       dph;       // data phase pending
    logic       dwr;       // data phase is write
    logic [7:0] daddr;     // data phase address
    logic [7:0] pdo;       // port c pin output value
    logic [7:0] poe;       // port c output enables
    logic       ready_strobe_output_pin;  // ready strobe pin level
    logic       irq;       // interrupt request
  } shpp_state_t;
endpackage

// ===== tb/shpp_periph_model.sv
// peripheral model on the strobe and port c pins
`timescale 1ns/1ps
module shpp_periph_model (
  input  wire logic       core_clk_in,  // bus clock
  input  wire logic       ready_in,     // ready strobe pin from the port
  input  wire logic       ready_act_in, // active level of that pin
  input  wire logic [7:0] pins_in,      // resolved port c lines
  output logic            strobe_out,   // edge strobe towards the port
  output logic [7:0]      data_out,     // byte put on port c
  output logic            data_oe_out,  // high while driving port c
  output logic [7:0]      got_out       // last byte taken
);
  initial begin
    strobe_out = 1'b0;
    data_out = 8'h00;
    data_oe_out = 1'b0;
    got_out = 8'h00;
  end
  // bounded wait: a port that never gets ready shows up as a bench mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_in !== ready_act_in && n < 200) begin
      @(posedge core_clk_in);
      n++;
    end
  endtask
  // long levels so the three-stage input filter always sees them
  task automatic set_strobe(input logic lvl);
    strobe_out <= lvl;
    repeat (8) @(posedge core_clk_in);
  endtask
  // keep driving a byte on port c
  task automatic drive(input logic [7:0] d);
    data_out <= d;
    data_oe_out <= 1'b1;
    @(posedge core_clk_in);
  endtask
  // input handshake: wait for ready, data first, then a rising strobe
  task automatic push(input logic hs, input logic [7:0] d);
    if (hs) wait_ready();
    drive(d);
    @(posedge core_clk_in);
    set_strobe(1'b1);
    set_strobe(1'b0);
  endtask
  // output handshake: take the byte, then acknowledge with a strobe
  task automatic ack();
    wait_ready();
    got_out <= pins_in;
    strobe_out <= 1'b1;
    repeat (11) @(posedge core_clk_in);
    set_strobe(1'b0);
  endtask
endmodule

// ===== tb/strobed_handshake_parallel_port_bench.sv
// self-checking bench for the strobed handshake parallel port
`timescale 1ns/1ps
`include "shpp_params.svh"
module strobed_handshake_parallel_port_bench;
  localparam logic [7:0] a_ctl = `SHPP_ADDR_CTRL;  // control
  localparam logic [7:0] a_pin = `SHPP_ADDR_PINC;  // live port c
  localparam logic [7:0] a_lat = `SHPP_ADDR_LATCH; // latched capture
  localparam logic [7:0] a_dir = `SHPP_ADDR_DIRC;  // direction
  localparam logic [7:0] a_pb  = `SHPP_ADDR_PORTB; // port b
  logic        core_clk_in;              // bus clock
  logic        rst_in      = 1'b1;       // held at start
  logic        hsel        = 1'b0;       // ahb master side
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic        single_chip = 1'b1;       // operating mode pin
  logic        irq_mask    = 1'b0;       // global interrupt mask
  logic [2:0]  hsize       = 3'h2;       // ahb size, whole words only
  logic        p_act       = 1'b1;       // ready level the peripheral waits for
  int          errors      = 0;
  int          checks_done = 0;
  int          cycles      = 0;          // timeout count
  logic        hready, hresp, ready_strobe_output, irq, p_ready_strobe_output, p_oe;
  logic [31:0] hrdata;
  logic [31:0] rd;                       // last read data
  logic [7:0]  pc_out, pc_oe, pb_out, p_data, p_got, pins;
  // undriven lines show the inverse so a stale value never passes
  assign pins = (pc_oe & pc_out) | (~pc_oe & (p_oe ? p_data : ~pc_out));
  shpp_port dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
    .hwdata_in(hwdata), .hreadyout_out(hready), .hrdata_out(hrdata),
    .hresp_out(hresp), .single_chip_in(single_chip), .irq_mask_in(irq_mask),
    .edge_strobe_input_in(p_ready_strobe_output), .port_c_in(pins), .port_c_out(pc_out),
    .port_c_oe_out(pc_oe), .port_b_out(pb_out),
    .ready_strobe_output_out(ready_strobe_output), .irq_out(irq));
  shpp_periph_model p (
    .core_clk_in(core_clk_in), .ready_in(ready_strobe_output), .ready_act_in(p_act),
    .pins_in(pins), .strobe_out(p_ready_strobe_output), .data_out(p_data),
    .data_oe_out(p_oe), .got_out(p_got));
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  // verdict and end of run
  task automatic complete_run();
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  // one ahb-lite single word transfer; waits on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk_in);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge core_clk_in);
      n++;
    end
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge core_clk_in);
    while (hready !== 1'b1 && n < 100) begin
      @(posedge core_clk_in);
      n++;
    end
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    cmp_reg(nm, {24'h0, e}, rd);
  endtask
  // count strobe pin cycles at the given level over a short window
  task automatic pulse(input logic lvl, input logic [7:0] e);
    int k;
    k = 0;
    repeat (10) begin
      @(posedge core_clk_in);
      if (ready_strobe_output === lvl) k++;
    end
    cmp_pin("strobe pulse", e, 8'(k));
  endtask
  initial begin
    tick(12);
    rst_in <= 1'b0;
    tick(1);
    rd_chk("ctrl reset", a_ctl, 8'h03);
    wr(a_ctl, 8'hFF);
    rd_chk("ctrl flag ro", a_ctl, 8'h7F);
    wr(`SHPP_ADDR_MISC, 8'h55);
    rd_chk("unmapped", `SHPP_ADDR_MISC, 8'h00);
    // simple strobe mode, both polarities
    wr(a_ctl, 8'h03);
    wr(a_pb, 8'hA5);
    pulse(1'b1, 8'h02);
    cmp_pin("port b", 8'hA5, pb_out);
    wr(a_ctl, 8'h02);
    wr(a_pb, 8'h5A);
    pulse(1'b0, 8'h02);
    // capture, flag, interrupt and clearing sequence
    wr(a_ctl, 8'h43);
    p.push(1'b0, 8'h3C);
    rd_chk("flag set", a_ctl, 8'hC3);
    cmp_pin("irq", 8'h01, {7'h0, irq});
    irq_mask <= 1'b1;
    tick(2);
    cmp_pin("irq masked", 8'h00, {7'h0, irq});
    irq_mask <= 1'b0;
    rd_chk("latched", a_lat, 8'h3C);
    rd_chk("flag cleared", a_ctl, 8'h43);
    // falling edge select ignores the rising edge
    wr(a_ctl, 8'h01);
    p.set_strobe(1'b1);
    rd_chk("rise ignored", a_ctl, 8'h01);
    p.set_strobe(1'b0);
    rd_chk("fall taken", a_ctl, 8'h81);
    rd_chk("latched", a_lat, 8'h3C);
    // outside single-chip mode nothing strobes
    single_chip <= 1'b0;
    wr(a_ctl, 8'h03);
    p.set_strobe(1'b1);
    p.set_strobe(1'b0);
    rd_chk("no flag", a_ctl, 8'h03);
    wr(a_pb, 8'h11);
    pulse(1'b1, 8'h00);
    single_chip <= 1'b1;
    // input handshake, interlocked
    wr(a_ctl, 8'h13);
    rd_chk("latched", a_lat, 8'h3C);
    tick(1);
    cmp_pin("ready up", 8'h01, {7'h0, ready_strobe_output});
    p.push(1'b1, 8'h5A);
    cmp_pin("ready down", 8'h00, {7'h0, ready_strobe_output});
    rd_chk("hs flag", a_ctl, 8'h93);
    rd_chk("hs latched", a_lat, 8'h5A);
    tick(1);
    cmp_pin("ready again", 8'h01, {7'h0, ready_strobe_output});
    p.drive(8'h81);
    rd_chk("live pins", a_pin, 8'h81);
    wr(a_pin, 8'h11);
    wr(a_lat, 8'h22);
    wr(a_dir, 8'hFF);
    tick(1);
    cmp_pin("shared latch", 8'h22, pc_out);
    cmp_pin("ready kept", 8'h01, {7'h0, ready_strobe_output});
    // output handshake, interlocked, three-state on the high nibble
    wr(a_dir, 8'h0F);
    wr(a_ctl, 8'h1B);
    wr(a_lat, 8'hC3);
    tick(1);
    cmp_pin("ready up", 8'h01, {7'h0, ready_strobe_output});
    cmp_pin("port c out", 8'hC3, pc_out);
    cmp_pin("forced oe", 8'hFF, pc_oe);
    rd_chk("out latch", a_pin, 8'hC3);
    fork
      p.ack();
      begin
        tick(9);
        cmp_pin("ddr oe", 8'h0F, pc_oe);
      end
    join
    cmp_pin("taken", 8'hC3, p_got);
    cmp_pin("ready down", 8'h00, {7'h0, ready_strobe_output});
    rd_chk("out flag", a_ctl, 8'h9B);
    wr(a_lat, 8'h44);
    rd_chk("out clear", a_ctl, 8'h1B);
    // pulsed ready with open-drain outputs
    wr(a_ctl, 8'h3F);
    wr(a_lat, 8'h0F);
    pulse(1'b1, 8'h02);
    cmp_pin("open drain", 8'hF0, pc_oe);
    complete_run();
  end
endmodule
